// *** rtl/rfcu_pkg.sv ***
package rfcu_pkg;

	// Special function register addresses seen by the core.
	localparam logic [7:0] ADDR_CMD     = 8'hd1;
	localparam logic [7:0] ADDR_COMM_EN = 8'hd2;
	localparam logic [7:0] ADDR_MISC_EN = 8'hd3;

	// Command register fields and reset value.
	localparam int         CMD_RCV_OFF_BIT = 5;
	localparam int         CMD_PWR_BIT     = 4;
	localparam int         CMD_CODE_LSB    = 0;
	localparam int         CMD_CODE_W      = 4;
	localparam logic       CMD_RCV_OFF_RST = 1'b1;
	localparam logic [3:0] CMD_CODE_RST    = 4'h0;

	// Enable register write masks and reset values.
	localparam int         COMM_W        = 7;
	localparam int         MISC_W        = 5;
	localparam logic [6:0] COMM_EN_RST   = 7'h00;
	localparam logic [4:0] MISC_EN_RST   = 5'h00;

	// Common enable bit positions.
	localparam int EN_TX      = 6;
	localparam int EN_RX      = 5;
	localparam int EN_IDLE    = 4;
	localparam int EN_HIALERT = 3;
	localparam int EN_LOALERT = 2;
	localparam int EN_ERR     = 1;
	localparam int EN_TIMER   = 0;

	// Miscellaneous enable bit positions.
	localparam int EN_SECURE_IC_SIGNAL_INPUT    = 4;
	localparam int EN_MODE     = 3;
	localparam int EN_CRC      = 2;
	localparam int EN_FIELD_ON = 1;
	localparam int EN_FIELD_OFF = 0;

	// Command codes; the full command set is decoded outside this block.
	localparam logic [3:0]  CMD_IDLE         = 4'h0;
	localparam logic [3:0]  CMD_SELF_REINIT  = 4'hf;
	localparam logic [15:0] CMD_VALID_MASK   = 16'h83ff;

	// Wake-up timing.
	localparam int CLK_FREQ_MHZ   = 50;
	localparam int WAKEUP_TIME_NS = 1000;
	localparam int WAKEUP_CYCLES  = (WAKEUP_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;

	typedef enum logic [1:0] {
		PWR_ON,
		PWR_DOWN,
		PWR_WAKING
	} rfcu_pwr_e;

endpackage

// *** rtl/rfcu_wakeup_timer.sv ***
`timescale 1ns/1ps
module rfcu_wakeup_timer #(
	parameter int CYCLES = rfcu_pkg::WAKEUP_CYCLES
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic resetn,
	// Control.
	input  wire logic start,
	input  wire logic abort,
	// Status.
	output logic      done
);

	localparam int CW = (CYCLES > 1) ? $clog2(CYCLES + 1) : 1;
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	if (CYCLES < 1) begin : g_chk
		$error("rfcu_wakeup_timer: CYCLES must be at least 1");
	end

	typedef struct packed {
		logic          busy;
		logic [CW-1:0] cnt;
		logic          done;
	} rfcu_wake_s;

	rfcu_wake_s s_r;
	rfcu_wake_s s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		if (abort) begin
			s_nxt.busy = 1'b0;
		end else if (start) begin
			s_nxt.busy = 1'b1;
			s_nxt.cnt = '0;
		end else if (s_r.busy) begin
			if (s_r.cnt == LAST) begin
				s_nxt.busy = 1'b0;
				s_nxt.done = 1'b1;
			end else begin
				s_nxt.cnt = s_r.cnt + CW'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign done = s_r.done;

endmodule // rfcu_wakeup_timer

// *** rtl/rfcu_irq_route.sv ***
`timescale 1ns/1ps
module rfcu_irq_route (
	// Clock and reset.
	input  wire logic                        clk,
	input  wire logic                        resetn,
	// Request flags and enables.
	input  wire logic [rfcu_pkg::COMM_W-1:0] commReq,
	input  wire logic [rfcu_pkg::COMM_W-1:0] commEn,
	input  wire logic [rfcu_pkg::MISC_W-1:0] miscReq,
	input  wire logic [rfcu_pkg::MISC_W-1:0] miscEn,
	// Interrupt lines.
	output logic                             irqLineZero,
	output logic                             irqLineOne
);

	typedef struct packed {
		logic zero;
		logic one;
	} rfcu_irq_s;

	rfcu_irq_s                      s_r;
	rfcu_irq_s                      s_nxt;
	logic [rfcu_pkg::COMM_W-1:0]    commHit;
	logic [rfcu_pkg::MISC_W-1:0]    miscHit;

	for (genvar i = 0; i < rfcu_pkg::COMM_W; i++) begin : g_comm
		assign commHit[i] = commReq[i] & commEn[i];
	end
	for (genvar j = 0; j < rfcu_pkg::MISC_W; j++) begin : g_misc
		assign miscHit[j] = miscReq[j] & miscEn[j];
	end

	always_comb begin
		s_nxt.one = commHit[rfcu_pkg::EN_TX]
			| commHit[rfcu_pkg::EN_RX]
			| commHit[rfcu_pkg::EN_HIALERT]
			| commHit[rfcu_pkg::EN_LOALERT];
		s_nxt.zero = commHit[rfcu_pkg::EN_IDLE]
			| commHit[rfcu_pkg::EN_ERR]
			| commHit[rfcu_pkg::EN_TIMER]
			| miscHit[rfcu_pkg::EN_SECURE_IC_SIGNAL_INPUT]
			| miscHit[rfcu_pkg::EN_MODE]
			| miscHit[rfcu_pkg::EN_CRC]
			| miscHit[rfcu_pkg::EN_FIELD_ON]
			| miscHit[rfcu_pkg::EN_FIELD_OFF];
	end

	// Lines follow the gated requests with one cycle of latency.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign irqLineZero = s_r.zero;
	assign irqLineOne  = s_r.one;

endmodule // rfcu_irq_route

// *** rtl/rfcu_command_ctrl.sv ***
`timescale 1ns/1ps
// Behaviour
// - Receiver-off bit 5 set switches the analog receiver off.
// - Power-down bit 4 set powers down analog blocks except the level detector.
// - Clearing bit 4 starts wake-up; bit reads 1 until ready.
// - Power-down cannot be set while the self-reinit command runs.
// - Writing the four-bit command field starts that command.
// - Reading the command field returns the command now executing.
// - Transmit-done enable bit 6 routes transmit-done to line one.
// - Receive-done enable bit 5 routes receive-done to line one.
// - Idle enable bit 4 routes the idle request to line zero.
// - High-alert enable bit 3 routes high-alert to line one.
// - Low-alert enable bit 2 routes low-alert to line one.
// - Error enable bit 1 routes the error request to line zero.
// - Timer enable bit 0 routes the timer request to line zero.
// - Misc bit 4 routes secure-input activity to line zero.
// - Misc bit 3 routes mode-detected to line zero.
// - Misc bit 2 routes checksum-done to line zero.
// - Misc bit 1 routes field-detected to line zero.
// - Misc bit 0 routes field-lost to line zero.
// - Command field returns to idle by itself when a command finishes.
// - Undefined command code returns field to idle and raises idle request.
module rfcu_command_ctrl #(
	parameter logic [15:0] VALID_MASK    = rfcu_pkg::CMD_VALID_MASK,
	parameter logic [3:0]  REINIT_CODE   = rfcu_pkg::CMD_SELF_REINIT,
	parameter int          WAKEUP_CYCLES = rfcu_pkg::WAKEUP_CYCLES
) (
	// Clock and reset.
	input  wire logic                        clk,
	input  wire logic                        resetn,
	// Special function register access.
	input  wire logic [7:0]                  sfrAddr,
	input  wire logic                        sfrWrEn,
	input  wire logic                        sfrRdEn,
	input  wire logic [7:0]                  sfrWdata,
	output logic [7:0]                       sfrRdata,
	// Command sequencing.
	input  wire logic                        cmdDone,
	output logic [3:0]                       commandCode,
	output logic                             commandStart,
	output logic                             idleRequestSet,
	// Analog control.
	output logic                             receiverOff,
	output logic                             analogPowerDown,
	output logic                             analogReady,
	// Request flags.
	input  wire logic [rfcu_pkg::COMM_W-1:0] commReq,
	input  wire logic [rfcu_pkg::MISC_W-1:0] miscReq,
	// Interrupt lines.
	output logic                             irqLineZero,
	output logic                             irqLineOne
);

	if (VALID_MASK[rfcu_pkg::CMD_IDLE] == 1'b0) begin : g_chk_idle
		$error("rfcu_command_ctrl: idle code must be a valid command");
	end
	if (WAKEUP_CYCLES < 1) begin : g_chk_wake
		$error("rfcu_command_ctrl: WAKEUP_CYCLES must be at least 1");
	end

	typedef struct packed {
		rfcu_pkg::rfcu_pwr_e         pwr;
		logic                        receiver_off;
		logic [3:0]                  cmd;
		logic                        cmdStart;
		logic                        idleSet;
		logic                        anaPd;
		logic                        anaReady;
		logic [rfcu_pkg::COMM_W-1:0] commEn;
		logic [rfcu_pkg::MISC_W-1:0] miscEn;
		logic [7:0]                  rdData;
	} rfcu_cmd_s;

	rfcu_cmd_s  s_r;
	rfcu_cmd_s  s_nxt;
	logic       wakeStart;
	logic       wakeAbort;
	logic       wakeDone;
	logic [3:0] wrCode;
	logic       wrCmd;

	assign wrCmd  = sfrWrEn && (sfrAddr == rfcu_pkg::ADDR_CMD);
	assign wrCode = sfrWdata[rfcu_pkg::CMD_CODE_LSB +: rfcu_pkg::CMD_CODE_W];

	always_comb begin
		s_nxt = s_r;
		s_nxt.cmdStart = 1'b0;
		s_nxt.idleSet = 1'b0;
		wakeStart = 1'b0;
		wakeAbort = 1'b0;

		// Wake-up completes only when the sequence timer expires.
		if (s_r.pwr == rfcu_pkg::PWR_WAKING && wakeDone) begin
			s_nxt.pwr = rfcu_pkg::PWR_ON;
		end

		// A finishing command drops back to idle unless software replaces it.
		if (cmdDone && s_r.cmd != rfcu_pkg::CMD_IDLE) begin
			s_nxt.cmd = rfcu_pkg::CMD_IDLE;
			s_nxt.idleSet = 1'b1;
		end

		if (wrCmd) begin
			s_nxt.receiver_off = sfrWdata[rfcu_pkg::CMD_RCV_OFF_BIT];
			if (sfrWdata[rfcu_pkg::CMD_PWR_BIT]) begin
				if (s_r.cmd != REINIT_CODE) begin
					s_nxt.pwr = rfcu_pkg::PWR_DOWN;
					wakeAbort = 1'b1;
				end
			end else if (s_r.pwr == rfcu_pkg::PWR_DOWN) begin
				s_nxt.pwr = rfcu_pkg::PWR_WAKING;
				wakeStart = 1'b1;
			end
			if (VALID_MASK[wrCode]) begin
				s_nxt.cmd = wrCode;
				s_nxt.idleSet = 1'b0;
				s_nxt.cmdStart = (wrCode != rfcu_pkg::CMD_IDLE);
			end else begin
				s_nxt.cmd = rfcu_pkg::CMD_IDLE;
				s_nxt.idleSet = 1'b1;
			end
		end else if (sfrWrEn && sfrAddr == rfcu_pkg::ADDR_COMM_EN) begin
			s_nxt.commEn = sfrWdata[rfcu_pkg::COMM_W-1:0];
		end else if (sfrWrEn && sfrAddr == rfcu_pkg::ADDR_MISC_EN) begin
			s_nxt.miscEn = sfrWdata[rfcu_pkg::MISC_W-1:0];
		end

		s_nxt.anaPd = (s_nxt.pwr == rfcu_pkg::PWR_DOWN);
		s_nxt.anaReady = (s_nxt.pwr == rfcu_pkg::PWR_ON);

		// Reads return the state of the cycle in which the strobe is seen.
		if (sfrRdEn) begin
			if (sfrAddr == rfcu_pkg::ADDR_CMD) begin
				s_nxt.rdData = {2'b00, s_r.receiver_off,
					(s_r.pwr != rfcu_pkg::PWR_ON),
					s_r.cmd};
			end else if (sfrAddr == rfcu_pkg::ADDR_COMM_EN) begin
				s_nxt.rdData = {1'b0, s_r.commEn};
			end else if (sfrAddr == rfcu_pkg::ADDR_MISC_EN) begin
				s_nxt.rdData = {3'b000, s_r.miscEn};
			end else begin
				s_nxt.rdData = 8'h00;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_r.pwr      <= rfcu_pkg::PWR_ON;
			s_r.receiver_off   <= rfcu_pkg::CMD_RCV_OFF_RST;
			s_r.cmd      <= rfcu_pkg::CMD_CODE_RST;
			s_r.cmdStart <= 1'b0;
			s_r.idleSet  <= 1'b0;
			s_r.anaPd    <= 1'b0;
			s_r.anaReady <= 1'b1;
			s_r.commEn   <= rfcu_pkg::COMM_EN_RST;
			s_r.miscEn   <= rfcu_pkg::MISC_EN_RST;
			s_r.rdData   <= 8'h00;
		end else begin
			s_r <= s_nxt;
		end
	end

	rfcu_wakeup_timer #(
		.CYCLES (WAKEUP_CYCLES)
	) u_wake (
		.clk    (clk),
		.resetn (resetn),
		.start  (wakeStart),
		.abort  (wakeAbort),
		.done   (wakeDone)
	);

	rfcu_irq_route u_irq (
		.clk         (clk),
		.resetn      (resetn),
		.commReq     (commReq),
		.commEn      (s_r.commEn),
		.miscReq     (miscReq),
		.miscEn      (s_r.miscEn),
		.irqLineZero (irqLineZero),
		.irqLineOne  (irqLineOne)
	);

	assign sfrRdata        = s_r.rdData;
	assign commandCode     = s_r.cmd;
	assign commandStart    = s_r.cmdStart;
	assign idleRequestSet  = s_r.idleSet;
	assign receiverOff     = s_r.receiver_off;
	assign analogPowerDown = s_r.anaPd;
	assign analogReady     = s_r.anaReady;

endmodule // rfcu_command_ctrl

// *** verification/rfcu_cmd_props.sv ***
`timescale 1ns/1ps
module rfcu_cmd_props #(
	parameter logic [15:0] VALID_MASK    = rfcu_pkg::CMD_VALID_MASK,
	parameter logic [3:0]  REINIT_CODE   = rfcu_pkg::CMD_SELF_REINIT,
	parameter int          WAKEUP_CYCLES = rfcu_pkg::WAKEUP_CYCLES
) (
	// Clock and reset.
	input wire logic       clk,
	input wire logic       resetn,
	// Register access.
	input wire logic [7:0] sfrAddr,
	input wire logic       sfrWrEn,
	input wire logic       sfrRdEn,
	input wire logic [7:0] sfrWdata,
	input wire logic [7:0] sfrRdata,
	// Command and analog.
	input wire logic       cmdDone,
	input wire logic [3:0] commandCode,
	input wire logic       commandStart,
	input wire logic       idleRequestSet,
	input wire logic       receiverOff,
	input wire logic       analogPowerDown,
	input wire logic       analogReady,
	// Requests and lines.
	input wire logic [6:0] commReq,
	input wire logic [4:0] miscReq,
	input wire logic       irqLineZero,
	input wire logic       irqLineOne
);
	localparam int WAKE_MAX = WAKEUP_CYCLES + 3;
	wire logic wrCmd = sfrWrEn && sfrAddr == rfcu_pkg::ADDR_CMD;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	a_cmd_start: assert property (
		wrCmd && VALID_MASK[sfrWdata[3:0]] && sfrWdata[3:0] != 4'h0
		|=> commandStart && commandCode == $past(sfrWdata[3:0])) else $error("start lost");
	a_undef_idle: assert property (
		wrCmd && !VALID_MASK[sfrWdata[3:0]] |=> idleRequestSet && commandCode == 4'h0)
		else $error("undefined code kept");
	a_idle_quiet: assert property (
		wrCmd && sfrWdata[3:0] == 4'h0 |=> commandCode == 4'h0 && !commandStart && !idleRequestSet)
		else $error("idle write misbehaved");
	a_done_idle: assert property (
		cmdDone && commandCode != 4'h0 && !wrCmd |=> commandCode == 4'h0 && idleRequestSet)
		else $error("command did not end");
	a_pd_enter: assert property (
		wrCmd && sfrWdata[4] && commandCode != REINIT_CODE |=> analogPowerDown && !analogReady)
		else $error("power-down not entered");
	a_pd_refused: assert property (
		wrCmd && sfrWdata[4] && commandCode == REINIT_CODE && !analogPowerDown
		|=> !analogPowerDown) else $error("power-down during reinit");
	a_wake_ready: assert property (
		$fell(analogPowerDown) |-> !analogReady ##[1:WAKE_MAX] (analogReady || analogPowerDown))
		else $error("wake-up too long");
	a_read_cmd: assert property (
		sfrRdEn && sfrAddr == rfcu_pkg::ADDR_CMD && !sfrWrEn |=> sfrRdata == {2'b00,
		$past(receiverOff), !$past(analogReady), $past(commandCode)}) else $error("bad cmd read");
	a_irq_quiet: assert property (
		commReq == 7'h00 && miscReq == 5'h00 |=> !irqLineZero && !irqLineOne)
		else $error("line without request");
	a_line_one: assert property (
		{commReq[6:5], commReq[3:2]} == 4'h0 |=> !irqLineOne) else $error("line one misrouted");

	c_start: cover property (commandStart);
	c_idle: cover property (idleRequestSet);
	c_wake: cover property ($rose(analogReady));
endmodule // rfcu_cmd_props

bind rfcu_command_ctrl rfcu_cmd_props #(.VALID_MASK(VALID_MASK), .REINIT_CODE(REINIT_CODE),
	.WAKEUP_CYCLES(WAKEUP_CYCLES)) rfcu_cmd_props_i (.clk, .resetn, .sfrAddr, .sfrWrEn, .sfrRdEn,
	.sfrWdata, .sfrRdata, .cmdDone, .commandCode, .commandStart, .idleRequestSet, .receiverOff,
	.analogPowerDown, .analogReady, .commReq, .miscReq, .irqLineZero, .irqLineOne);

// *** verification/rfcu_command_ctrl_test.sv ***
`timescale 1ns/1ps
module rfcu_command_ctrl_test;
	logic       clk, resetn, sfrWrEn, sfrRdEn, cmdDone;
	logic [7:0] sfrAddr, sfrWdata, sfrRdata;
	logic [3:0] commandCode;
	logic       commandStart, idleRequestSet, receiverOff, analogPowerDown, analogReady;
	logic [6:0] commReq;
	logic [4:0] miscReq;
	logic       irqLineZero, irqLineOne;
	int         err_count = 0;
	int         num_checks = 0;
	int         cycles = 0;

	rfcu_command_ctrl #(.WAKEUP_CYCLES(2)) rfcu_command_ctrl_i (.clk, .resetn, .sfrAddr,
		.sfrWrEn, .sfrRdEn, .sfrWdata, .sfrRdata, .cmdDone, .commandCode, .commandStart,
		.idleRequestSet, .receiverOff, .analogPowerDown, .analogReady, .commReq, .miscReq,
		.irqLineZero, .irqLineOne);

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfrAddr <= a;
		sfrWdata <= d;
		sfrWrEn <= 1'b1;
		@(posedge clk);
		sfrWrEn <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		sfrAddr <= a;
		sfrRdEn <= 1'b1;
		@(posedge clk);
		sfrRdEn <= 1'b0;
		#1;
		chk(sfrRdata, exp);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic t_regs;
		chk({receiverOff, analogReady, analogPowerDown}, 8'h06);
		rd(rfcu_pkg::ADDR_CMD, 8'h20);
		wr(rfcu_pkg::ADDR_COMM_EN, 8'hff);
		rd(rfcu_pkg::ADDR_COMM_EN, 8'h7f);
		wr(rfcu_pkg::ADDR_MISC_EN, 8'hff);
		rd(rfcu_pkg::ADDR_MISC_EN, 8'h1f);
		wr(8'hd4, 8'hff);
		rd(8'hd4, 8'h00);
		wr(rfcu_pkg::ADDR_COMM_EN, 8'h00);
		wr(rfcu_pkg::ADDR_MISC_EN, 8'h00);
		$display("test registers done");
	endtask
	task automatic t_irq;
		logic [11:0] one;
		logic [7:0]  a;
		logic [7:0]  d;
		for (int i = 0; i < 12; i++) begin
			one = 12'h001 << i;
			a = (i < 7) ? rfcu_pkg::ADDR_COMM_EN : rfcu_pkg::ADDR_MISC_EN;
			d = (i < 7) ? {1'b0, one[6:0]} : {3'b000, one[11:7]};
			@(posedge clk);
			{miscReq, commReq} <= one;
			// Every other enable in that register on: the request must stay blocked.
			wr(a, ~d);
			repeat (2) @(posedge clk);
			#1;
			chk({irqLineOne, irqLineZero}, 8'h00);
			wr(a, d);
			repeat (2) @(posedge clk);
			#1;
			if ((one & 12'h06c) != 12'h000)
				chk({irqLineOne, irqLineZero}, 8'h02);
			else if (i < 7)
				chk({irqLineOne, irqLineZero}, 8'h01);
			else
				chk({irqLineOne, irqLineZero}, 8'h01);
			wr(a, 8'h00);
			repeat (2) @(posedge clk);
			#1;
			chk({irqLineOne, irqLineZero}, 8'h00);
			@(posedge clk);
			{miscReq, commReq} <= 12'h000;
		end
		$display("test interrupts done");
	endtask
	task automatic t_cmd;
		wr(rfcu_pkg::ADDR_CMD, 8'h01);
		chk({commandStart, commandCode}, 8'h11);
		chk(receiverOff, 1'b0);
		rd(rfcu_pkg::ADDR_CMD, 8'h01);
		@(posedge clk);
		cmdDone <= 1'b1;
		@(posedge clk);
		cmdDone <= 1'b0;
		#1;
		chk({idleRequestSet, commandCode}, 8'h10);
		wr(rfcu_pkg::ADDR_CMD, 8'h0a);
		chk({idleRequestSet, commandStart, commandCode}, 8'h20);
		wr(rfcu_pkg::ADDR_CMD, 8'h20);
		chk({idleRequestSet, commandStart, commandCode}, 8'h00);
		$display("test commands done");
	endtask
	task automatic t_power;
		wr(rfcu_pkg::ADDR_CMD, 8'h30);
		chk({analogPowerDown, analogReady}, 8'h02);
		rd(rfcu_pkg::ADDR_CMD, 8'h30);
		wr(rfcu_pkg::ADDR_CMD, 8'h20);
		chk({analogPowerDown, analogReady}, 8'h00);
		rd(rfcu_pkg::ADDR_CMD, 8'h30);
		repeat (8) @(posedge clk);
		rd(rfcu_pkg::ADDR_CMD, 8'h20);
		chk({analogPowerDown, analogReady}, 8'h01);
		// Power-down set again in mid wake-up must cancel the wake-up.
		wr(rfcu_pkg::ADDR_CMD, 8'h30);
		wr(rfcu_pkg::ADDR_CMD, 8'h20);
		wr(rfcu_pkg::ADDR_CMD, 8'h30);
		repeat (8) @(posedge clk);
		#1;
		chk({analogPowerDown, analogReady}, 8'h02);
		wr(rfcu_pkg::ADDR_CMD, 8'h20);
		repeat (8) @(posedge clk);
		#1;
		chk({analogPowerDown, analogReady}, 8'h01);
		wr(rfcu_pkg::ADDR_CMD, 8'h2f);
		wr(rfcu_pkg::ADDR_CMD, 8'h3f);
		chk({analogPowerDown, commandCode}, 8'h0f);
		wr(rfcu_pkg::ADDR_CMD, 8'h20);
		$display("test power done");
	endtask

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			summarize();
		end
	end
	initial begin
		resetn = 1'b0;
		sfrWrEn = 1'b0;
		sfrRdEn = 1'b0;
		sfrAddr = 8'h00;
		sfrWdata = 8'h00;
		cmdDone = 1'b0;
		commReq = 7'h00;
		miscReq = 5'h00;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		#1;
		t_regs();
		t_irq();
		t_cmd();
		t_power();
		summarize();
	end
endmodule // rfcu_command_ctrl_test
